// >>> hw/sub_pkg.sv
// shared constants for the subtract datapath
package sub_pkg;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int DC_BIT = 4;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    localparam int INSTR_CYCLES = 1;
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_LIT_SUB = 2'b01,
        OP_FILE_SUB = 2'b10
    } sub_op_e;
endpackage

// >>> hw/sub_if.sv
// operand and result bundle between controller and subtractor
`timescale 1ns/1ns
interface sub_if;
    logic [7:0] minuend;
    logic [7:0] subtrahend;
    logic [7:0] diff;
    logic carry;
    logic digitCarry;
    logic zero;
    modport user (output minuend, output subtrahend,
        input diff, input carry, input digitCarry, input zero);
    modport alu (input minuend, input subtrahend,
        output diff, output carry, output digitCarry, output zero);
endinterface

// >>> hw/sub_alu.sv
// combinational two's-complement subtractor with flag generation
`timescale 1ns/1ns
module sub_alu (
    sub_if.alu bus
);
    import sub_pkg::*;
    logic [8:0] sum;
    logic [4:0] low;
    // minuend + ~subtrahend + 1; carry out is the inverted borrow
    assign sum = {1'b0, bus.minuend} + {1'b0, ~bus.subtrahend} + 9'h001;
    assign low = {1'b0, bus.minuend[3:0]} + {1'b0, ~bus.subtrahend[3:0]}
        + 5'h01;
    assign bus.diff = sum[7:0]; // RULE6
    assign bus.carry = sum[8]; // RULE4 RULE5 RULE6
    assign bus.digitCarry = low[DC_BIT]; // RULE7
    assign bus.zero = (sum[7:0] == 8'h00); // RULE7
endmodule

// >>> hw/subtract_datapath.sv
// execution datapath for literal and file subtract instructions
// Function
// RULE1: literal minus accumulator goes into the accumulator.
// RULE2: file register minus accumulator is computed for the file subtract.
// RULE3: destination bit 0 writes the accumulator, 1 writes the file register.
// RULE4: carry is 1 when the difference is zero.
// RULE5: carry is 1 when the difference is positive.
// RULE6: carry is 0 on a negative difference and the result wraps to 8 bits.
// RULE7: one cycle per instruction, zero and digit carry from the result.
`timescale 1ns/1ns
module subtract_datapath (
    input wire logic sys_clk,
    input wire logic rst,
    input wire sub_pkg::sub_op_e op,
    input wire logic [7:0] literal,
    input wire logic [7:0] fileData,
    input wire logic [sub_pkg::FADDR_W-1:0] fileAddr,
    input wire logic destSel,
    output logic [7:0] accumulator_q,
    output logic carryFlag_q,
    output logic digit_carry_flag_q,
    output logic zeroFlag_q,
    output logic fileWrite_q,
    output logic [sub_pkg::FADDR_W-1:0] fileWrAddr_q,
    output logic [7:0] fileWrData_q,
    output logic done_q
);
    import sub_pkg::*;
    sub_if alu();
    logic isSub;
    logic toFile;

    sub_alu u_alu (
        .bus(alu.alu)
    );

    // opcode decode shared by the datapath and its checks
    // a refused opcode is simply not a subtract and changes nothing
    function automatic logic isSubOp(input sub_op_e o);
        return (o == OP_LIT_SUB) || (o == OP_FILE_SUB);
    endfunction

    // only the file subtract honours the destination bit
    function automatic logic writesFile(input sub_op_e o, input logic d);
        return (o == OP_FILE_SUB) && (d == DEST_FILE);
    endfunction

    assign isSub = isSubOp(op);
    assign toFile = writesFile(op, destSel);

    always_comb begin
        case (op)
            OP_LIT_SUB: alu.minuend = literal; // RULE1
            OP_FILE_SUB: alu.minuend = fileData; // RULE2
            default: alu.minuend = 8'h00;
        endcase
    end
    assign alu.subtrahend = accumulator_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            accumulator_q <= ACC_RESET;
        end else if (isSub && !toFile) begin
            accumulator_q <= alu.diff; // RULE1 RULE3
        end
    end

    // file write is a single-cycle strobe; the register file owns storage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fileWrite_q <= 1'b0;
            fileWrAddr_q <= '0;
            fileWrData_q <= 8'h00;
        end else begin
            fileWrite_q <= toFile; // RULE3
            if (toFile) begin
                fileWrAddr_q <= fileAddr;
                fileWrData_q <= alu.diff;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            carryFlag_q <= FLAG_RESET;
            digit_carry_flag_q <= FLAG_RESET;
            zeroFlag_q <= FLAG_RESET;
        end else if (isSub) begin
            carryFlag_q <= alu.carry; // RULE4 RULE5 RULE6
            digit_carry_flag_q <= alu.digitCarry; // RULE7
            zeroFlag_q <= alu.zero; // RULE7
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= isSub; // RULE7
        end
    end

    // independent operand pick so a mux fault shows up in the flag checks
    logic [7:0] chkMinuend;
    assign chkMinuend = (op == OP_LIT_SUB) ? literal : fileData;

    default clocking assertClk @(posedge sys_clk);
    endclocking
    // the reset check below opts back in on its own
    default disable iff (rst);

    sequence litIssue;
        op == OP_LIT_SUB;
    endsequence

    sequence fileIssue;
        op == OP_FILE_SUB;
    endsequence

    sequence subIssue;
        op == OP_LIT_SUB || op == OP_FILE_SUB;
    endsequence

    sequence noIssue;
        op != OP_LIT_SUB && op != OP_FILE_SUB;
    endsequence

    sequence fileToAcc;
        fileIssue ##0 destSel == DEST_ACC;
    endsequence

    sequence fileToFile;
        fileIssue ##0 destSel == DEST_FILE;
    endsequence

    // both flavours subtract the accumulator from the picked minuend
    sequence sameOperands;
        subIssue ##0 chkMinuend == accumulator_q;
    endsequence

    sequence biggerMinuend;
        subIssue ##0 chkMinuend > accumulator_q;
    endsequence

    sequence smallerMinuend;
        subIssue ##0 chkMinuend < accumulator_q;
    endsequence

    lit_result_a: assert property (litIssue |=> // RULE1
        accumulator_q == 8'($past(literal) - $past(accumulator_q)))
        else $error("literal result wrong");

    lit_no_write_a: assert property (litIssue |=> // RULE1
        !fileWrite_q && $stable(fileWrData_q))
        else $error("literal touched the file register");

    file_acc_a: assert property (fileToAcc |=> // RULE2
        accumulator_q == 8'($past(fileData) - $past(accumulator_q)) &&
        !fileWrite_q)
        else $error("file to acc wrong");

    file_dest_a: assert property (fileToFile |=> // RULE3
        fileWrite_q &&
        fileWrData_q == 8'($past(fileData) - $past(accumulator_q)) &&
        accumulator_q == $past(accumulator_q))
        else $error("file dest wrong");

    file_addr_a: assert property (fileToFile |=> // RULE3
        fileWrAddr_q == $past(fileAddr))
        else $error("file write address wrong");

    // the register file may look at address and data with the strobe low
    file_hold_a: assert property ( // RULE3
        !writesFile(op, destSel) |=> !fileWrite_q &&
        $stable(fileWrAddr_q) && $stable(fileWrData_q))
        else $error("file write port moved without a write");

    file_pulse_a: assert property ( // RULE3
        fileToFile ##1 !writesFile(op, destSel) |->
        fileWrite_q ##1 !fileWrite_q)
        else $error("file write strobe not one cycle");

    zero_carry_a: assert property ( // RULE4
        sameOperands |=> carryFlag_q && zeroFlag_q)
        else $error("zero result carry wrong");

    pos_carry_a: assert property ( // RULE5
        biggerMinuend |=> carryFlag_q && !zeroFlag_q)
        else $error("positive carry wrong");

    // a negative difference wraps, so it can never read as zero
    neg_carry_a: assert property ( // RULE6
        smallerMinuend |=> !carryFlag_q && !zeroFlag_q)
        else $error("negative carry wrong");

    neg_wrap_a: assert property ( // RULE6
        smallerMinuend ##0 litIssue |=> accumulator_q > $past(literal))
        else $error("negative result did not wrap");

    digit_carry_a: assert property (subIssue |=> // RULE7
        digit_carry_flag_q ==
        ($past(chkMinuend[3:0]) >= $past(accumulator_q[3:0])))
        else $error("digit carry wrong");

    zero_flag_a: assert property (subIssue |=> // RULE7
        zeroFlag_q == ($past(chkMinuend) == $past(accumulator_q)))
        else $error("zero flag wrong");

    one_cycle_a: assert property (subIssue ##1 noIssue |-> // RULE7
        done_q ##1 !done_q)
        else $error("done timing wrong");

    idle_done_a: assert property (noIssue |=> !done_q) // RULE7
        else $error("done without a subtract");

    // a refused or idle opcode leaves the architectural state alone
    idle_hold_a: assert property (noIssue |=> // RULE7
        $stable(accumulator_q) && $stable(carryFlag_q) &&
        $stable(digit_carry_flag_q) && $stable(zeroFlag_q))
        else $error("idle opcode changed state");

    reset_clear_a: assert property (disable iff (1'b0) rst |=> // RULE1
        accumulator_q == ACC_RESET && carryFlag_q == FLAG_RESET &&
        digit_carry_flag_q == FLAG_RESET && zeroFlag_q == FLAG_RESET &&
        !fileWrite_q && !done_q && fileWrData_q == 8'h00)
        else $error("reset left state behind");
endmodule

// >>> testbench/testbench.sv
// self-checking bench for the subtract datapath
`timescale 1ns/1ns
module testbench;
import sub_pkg::*;
logic sys_clk = 1'b0;
logic rst = 1'b1;
sub_op_e op = OP_NONE;
logic [7:0] literal = 8'h00;
logic [7:0] fileData = 8'h00;
logic [FADDR_W-1:0] fileAddr = '0;
logic destSel = 1'b0;
logic [7:0] acc, fwd;
logic cf, dcf, zf, fw, done;
logic [FADDR_W-1:0] fwa;
logic [7:0] accM = ACC_RESET;
logic cM = FLAG_RESET, dM = FLAG_RESET, zM = FLAG_RESET;
int fails = 0;
int comparisons = 0;
always #4 sys_clk = ~sys_clk;
subtract_datapath u_subtract_datapath (.sys_clk(sys_clk), .rst(rst),
    .op(op), .literal(literal), .fileData(fileData), .fileAddr(fileAddr),
    .destSel(destSel), .accumulator_q(acc), .carryFlag_q(cf),
    .digit_carry_flag_q(dcf), .zeroFlag_q(zf), .fileWrite_q(fw),
    .fileWrAddr_q(fwa), .fileWrData_q(fwd), .done_q(done));
task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
        fails++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task chkFlag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
        fails++;
        $display("wrong value at %0t: flag got %b expected %b", $time, got,
            exp);
    end
endtask
// expected difference and no-borrow test, straight from the rules
function automatic logic [7:0] expDiff(input logic [7:0] m,
    input logic [7:0] s);
    return m - s;
endfunction
function automatic logic noBorrow(input logic [7:0] m, input logic [7:0] s);
    return m >= s;
endfunction
task end_of_test;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
// drives one instruction at a falling edge, checks a cycle later
task run(input sub_op_e o, input logic [7:0] k, input logic [7:0] f,
         input logic d);
    logic [7:0] m, r;
    logic sub, wr;
    logic [FADDR_W-1:0] a;
    sub = (o == OP_LIT_SUB) || (o == OP_FILE_SUB);
    wr = (o == OP_FILE_SUB) && (d == DEST_FILE);
    m = (o == OP_LIT_SUB) ? k : f;
    r = expDiff(m, accM);
    a = FADDR_W'($urandom);
    op = o;
    literal = k;
    fileData = f;
    fileAddr = a;
    destSel = d;
    repeat (INSTR_CYCLES) @(negedge sys_clk);
    if (sub) begin
        cM = noBorrow(m, accM);
        dM = noBorrow({4'h0, m[3:0]}, {4'h0, accM[3:0]});
        zM = r == 8'h00;
        if (!wr)
            accM = r;
    end
    chkFlag(done, sub);
    chkFlag(fw, wr);
    if (wr) chk(fwd, r);
    if (wr) chk(8'(fwa), 8'(a));
    chk(acc, accM);
    chkFlag(cf, cM);
    chkFlag(dcf, dM);
    chkFlag(zf, zM);
endtask
// one instruction with every field drawn at random, refused opcode included
task runRandom;
    sub_op_e o;
    o = sub_op_e'($urandom_range(0, 3));
    run(o, 8'($urandom), 8'($urandom), 1'($urandom));
endtask
// two reset cycles, then every output must be back at its reset value
task applyReset;
    rst = 1'b1;
    op = OP_NONE;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    accM = ACC_RESET;
    cM = FLAG_RESET;
    dM = FLAG_RESET;
    zM = FLAG_RESET;
    chk(acc, accM);
    chk(fwd, 8'h00);
    chk(8'(fwa), 8'h00);
    chkFlag(fw, 1'b0);
    chkFlag(done, 1'b0);
    chkFlag(cf, cM);
    chkFlag(dcf, dM);
    chkFlag(zf, zM);
endtask
logic [7:0] walk [7] = '{8'h01, 8'h02, 8'h03, 8'h02, 8'h03, 8'h02, 8'h01};
initial begin
    void'($urandom(37));
    applyReset();
    // walks positive, zero and negative literal results, back to back
    foreach (walk[i])
        run(OP_LIT_SUB, walk[i], 8'h00, DEST_FILE);
    run(OP_FILE_SUB, 8'h00, 8'h03, DEST_FILE);
    run(OP_FILE_SUB, 8'h00, 8'h02, DEST_FILE);
    run(OP_FILE_SUB, 8'h00, 8'h01, DEST_FILE);
    run(sub_op_e'(2'b11), 8'h55, 8'h66, 1'b0);
    run(OP_FILE_SUB, 8'h00, 8'h01, DEST_ACC);
    run(OP_NONE, 8'h12, 8'h34, 1'b0);
    repeat (150)
        runRandom();
    // reset in mid-run, then a zero difference from the cleared accumulator
    applyReset();
    run(OP_FILE_SUB, 8'h00, 8'h00, DEST_ACC);
    repeat (150)
        runRandom();
    end_of_test();
end
// hang guard well past the few hundred cycles of stimulus
initial begin
    #20000;
    fails++;
    end_of_test();
end
endmodule
